// File: core/two_wire_master_byte_engine.sv
// two-wire master byte engine with slave address watch, AXI4-Lite registers
// What this block does
// [R1] half periods of the serial clock follow the 8-bit baud field
// [R2] writing the target address register starts Start plus address
// [R3] unknown bus state on address write sets write and bus error flags
// [R4] busy bus: wait idle, Start, load address, send it, sample acknowledge
// [R5] after a write or unacknowledged read address, hold clock low unless arbitration lost; set write flag
// [R6] owned bus gives repeated Start; after a read, acknowledge goes first
// [R7] read address receives one byte before the read flag is set
// [R8] address write clears read, write, arbitration lost and bus error
// [R9] reading the target address register starts no bus activity
// [R10] address bit 0 is the read/not-write direction
// [R11] shift data register writes during shifting are ignored
// [R12] software touches data only while the clock is held low
// [R13] data write sends the byte, samples acknowledge, then sets write flag
// [R14] software checks arbitration lost after each write and recovers
// [R15] all bits clock out after arbitration loss, only ones driven
// [R16] data write clears read and write flags, keeps error flags
// [R17] data read sends acknowledge action, then receives exactly one byte
// [R18] nack lost or bus error on read sets write flag, never both
// [R19] data read clears read and write flags, keeps error flags
// [R20] slave data interrupt needs enable, data flag and global enable
// [R21] stop sets shared address-or-stop flag when stop enable is set
// [R22] promiscuous bit accepts every address, else own address only
// [R23] acknowledge action 0 sends ack, 1 sends nack, plain bit
// [R24] bus state codes: unknown, idle, owner, busy
// [R25] clock phases count system cycles against baud-derived count
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module two_wire_master_byte_engine
  import two_wire_master_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              sclIn,
  output logic                   sclOut,
  output logic                   sclOe,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  input  wire logic              globalIrqEnable,
  output logic                   slaveDataIrq,
  output logic                   slaveAddrStopIrq
);
  typedef enum logic [3:0]
  {
    MS_IDLE, MS_WAIT, MS_START, MS_TXBIT, MS_RXACK,
    MS_RXBIT, MS_ACKTX, MS_RSTART, MS_HOLD
  } mstate_t;

  typedef struct packed
  {
    mstate_t    ms;
    logic       ph;
    logic [2:0] bitCnt;
    logic [8:0] cnt;
    logic [7:0] baud;
    logic [7:0] addr;
    logic [7:0] shift;
    logic       enable;
    logic       acknowledge_action;
    logic       master_read_flag;
    logic       master_write_flag;
    logic       clock_hold_flag;
    logic       rxAck;
    logic       arbitration_lost_flag;
    logic       bus_error_flag;
    bus_state_t bus;
    logic       addrPhase;
    logic       lastRead;
    logic       restart;
    logic       lost;
    logic       sclOe;
    logic       sdaOe;
    logic [7:0] sctrl;
    logic [7:0] sown;
    logic       sDataF;
    logic       sApF;
    logic       sAp;
    logic [3:0] sBits;
    logic [6:0] sShift;
    logic       sFirst;
    logic       sInFrame;
    logic       sMatched;
    logic       sclS1;
    logic       sclS2;
    logic       sdaS1;
    logic       sdaS2;
    logic       sclP;
    logic       sdaP;
    logic       awRdy;
    logic       wRdy;
    logic [3:0] awIdx;
    logic [7:0] wByte;
    logic       bValid;
    logic [1:0] bResp;
    logic       arRdy;
    logic       rValid;
    logic [7:0] rByte;
    logic [1:0] rResp;
    logic       dataIrq;
    logic       apIrq;
  } state_t;

  state_t q;
  state_t d;

  logic       doWrite;
  logic       doRead;
  logic [3:0] arIdx;
  logic [7:0] rd;
  logic       mapped;
  logic       tick;
  logic       startSeen;
  logic       stopSeen;
  logic       sclRise;
  logic       shifting;
  logic       idleOrHold;
  logic       addrWr;
  logic       dataWr;
  logic [8:0] halfCount;
  logic [7:0] rxByte;

  assign awready          = q.awRdy;
  assign wready           = q.wRdy;
  assign bvalid           = q.bValid;
  assign bresp            = q.bResp;
  assign arready          = q.arRdy;
  assign rvalid           = q.rValid;
  assign rresp            = q.rResp;
  assign rdata            = {24'h000000, q.rByte};
  // open drain: only a low is ever driven
  assign sclOut           = 1'b0;
  assign sdaOut           = 1'b0;
  assign sclOe            = q.sclOe;
  assign sdaOe            = q.sdaOe;
  assign slaveDataIrq     = q.dataIrq;
  assign slaveAddrStopIrq = q.apIrq;

  assign doWrite    = !q.awRdy && !q.wRdy && !q.bValid;
  assign doRead     = arvalid && q.arRdy;
  assign arIdx      = araddr[5:2];
  assign halfCount  = {1'b0, q.baud} + HALF_EXTRA; // [R1]
  assign tick       = q.cnt >= halfCount; // [R25]
  assign startSeen  = q.sclS2 && q.sclP && q.sdaP && !q.sdaS2;
  assign stopSeen   = q.sclS2 && q.sclP && !q.sdaP && q.sdaS2;
  assign sclRise    = q.sclS2 && !q.sclP;
  assign shifting   = q.ms inside {MS_TXBIT, MS_RXACK, MS_RXBIT, MS_ACKTX};
  assign idleOrHold = q.ms == MS_IDLE || q.ms == MS_HOLD;
  assign addrWr     = doWrite && q.awIdx == IDX_MASTER_TARGET_ADDRESS && q.enable && idleOrHold;
  assign dataWr     = doWrite && q.awIdx == IDX_MASTER_SHIFT_DATA;
  assign rxByte     = {q.sShift, q.sdaS2};

  always_comb
  begin
    rd     = RST_BYTE;
    mapped = 1'b1;
    unique case (arIdx)
      IDX_MCTRL:
      begin
        rd[MC_ENABLE] = q.enable;
        rd[MC_ACKNOWLEDGE_ACTION] = q.acknowledge_action;
      end
      IDX_MASTER_STATUS_REG:
      begin
        rd[ST_RIF]          = q.master_read_flag;
        rd[ST_WIF]          = q.master_write_flag;
        rd[ST_CLOCK_HOLD_FLAG]      = q.clock_hold_flag;
        rd[ST_RXACK]        = q.rxAck;
        rd[ST_ARBITRATION_LOST_FLAG]      = q.arbitration_lost_flag;
        rd[ST_BUS_ERROR_FLAG]       = q.bus_error_flag;
        rd[ST_BUS +: 2]     = q.bus;
      end
      IDX_MASTER_BAUD_RATE:   rd = q.baud;
      IDX_MASTER_TARGET_ADDRESS:   rd = q.addr; // [R9]
      IDX_MASTER_SHIFT_DATA:   rd = q.shift;
      IDX_SLAVE_CONTROL_FIRST:  rd = q.sctrl;
      IDX_SLAVE_STATUS_REG:
      begin
        rd[SS_DIF]  = q.sDataF;
        rd[SS_SLAVE_ADDR_STOP_FLAG] = q.sApF;
        rd[SS_AP]   = q.sAp;
      end
      IDX_SLAVE_OWN_ADDRESS:   rd = q.sown;
      default:     mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    d       = q;
    d.sclS1 = sclIn;
    d.sclS2 = q.sclS1;
    d.sdaS1 = sdaIn;
    d.sdaS2 = q.sdaS1;
    d.sclP  = q.sclS2;
    d.sdaP  = q.sdaS2;
    d.dataIrq = q.sctrl[SC_SLAVE_DATA_IRQ_ENABLE] && q.sDataF && globalIrqEnable; // [R20]
    d.apIrq   = q.sctrl[SC_SLAVE_ADDR_STOP_IRQ_ENABLE] && q.sApF && globalIrqEnable;
    // bus handshakes: one write and one read in flight
    if (awvalid && q.awRdy)
    begin
      d.awRdy = 1'b0;
      d.awIdx = awaddr[5:2];
    end
    if (wvalid && q.wRdy)
    begin
      d.wRdy  = 1'b0;
      d.wByte = wstrb[0] ? wdata[7:0] : q.wByte;
    end
    if (doWrite)
    begin
      d.bValid = 1'b1;
      d.bResp  = RESP_OKAY;
      if (!(q.awIdx inside {IDX_MCTRL, IDX_MASTER_STATUS_REG, IDX_MASTER_BAUD_RATE, IDX_MASTER_TARGET_ADDRESS,
                            IDX_MASTER_SHIFT_DATA, IDX_SLAVE_CONTROL_FIRST, IDX_SLAVE_STATUS_REG, IDX_SLAVE_OWN_ADDRESS}))
        d.bResp = RESP_DECERR;
    end
    if (q.bValid && bready)
    begin
      d.bValid = 1'b0;
      d.awRdy  = 1'b1;
      d.wRdy   = 1'b1;
    end
    if (doRead)
    begin
      d.arRdy  = 1'b0;
      d.rValid = 1'b1;
      d.rByte  = rd;
      d.rResp  = mapped ? RESP_OKAY : RESP_DECERR;
    end
    if (q.rValid && rready)
    begin
      d.rValid = 1'b0;
      d.arRdy  = 1'b1;
    end
    // plain register writes and clear-by-one, before hardware sets
    if (doWrite)
    begin
      unique case (q.awIdx)
        IDX_MCTRL:
        begin
          d.enable = q.wByte[MC_ENABLE];
          d.acknowledge_action = q.wByte[MC_ACKNOWLEDGE_ACTION]; // [R23]
        end
        IDX_MASTER_STATUS_REG:
        begin
          d.master_read_flag     = q.master_read_flag && !q.wByte[ST_RIF];
          d.master_write_flag     = q.master_write_flag && !q.wByte[ST_WIF];
          d.arbitration_lost_flag = q.arbitration_lost_flag && !q.wByte[ST_ARBITRATION_LOST_FLAG];
          d.bus_error_flag  = q.bus_error_flag && !q.wByte[ST_BUS_ERROR_FLAG];
          if (q.wByte[ST_BUS +: 2] == BUS_IDLE)
            d.bus = BUS_IDLE;
        end
        // changing this while enabled gives undefined bit timing
        IDX_MASTER_BAUD_RATE:   d.baud = q.wByte; // [R1]
        IDX_SLAVE_CONTROL_FIRST:  d.sctrl = q.wByte;
        IDX_SLAVE_STATUS_REG:
        begin
          d.sDataF = q.sDataF && !q.wByte[SS_DIF];
          d.sApF   = q.sApF && !q.wByte[SS_SLAVE_ADDR_STOP_FLAG];
        end
        IDX_SLAVE_OWN_ADDRESS:   d.sown = q.wByte;
        default:     d.sown = q.sown;
      endcase
    end
    // bus state tracking
    if (q.enable)
    begin
      if (startSeen)
        d.bus = (q.ms == MS_START) ? BUS_OWNER : BUS_BUSY; // [R24]
      if (stopSeen)
        d.bus = BUS_IDLE;
      if ((startSeen || stopSeen) && shifting)
        d.bus_error_flag = 1'b1;
    end
    // phase counter; a slave stretching scl holds the high-phase count at zero
    d.cnt = tick ? 9'h000 : q.cnt + 9'h001; // [R25]
    if ((q.ph && !q.sclS2) || !(shifting || q.ms inside {MS_START, MS_RSTART}))
      d.cnt = 9'h000;
    unique case (q.ms)
      MS_IDLE, MS_HOLD:
        d.cnt = 9'h000;
      MS_WAIT:
        if (q.bus == BUS_IDLE)
        begin
          d.ms    = MS_START;
          d.sdaOe = 1'b1;
        end
      MS_START:
        if (tick)
        begin
          d.sclOe  = 1'b1;
          d.ms     = MS_TXBIT;
          d.ph     = 1'b0;
          d.bitCnt = 3'h7;
          d.shift  = q.addr; // [R4]
        end
      MS_TXBIT:
        if (!q.ph)
        begin
          d.sdaOe = !(q.shift[7] || q.lost); // [R15]
          if (tick)
          begin
            d.sclOe = 1'b0;
            d.ph    = 1'b1;
          end
        end
        else if (tick)
        begin
          if (!q.sdaOe && !q.sdaS2 && !q.lost)
          begin
            d.lost    = 1'b1;
            d.arbitration_lost_flag = 1'b1;
          end
          d.shift = {q.shift[6:0], 1'b0};
          d.sclOe = 1'b1;
          d.ph    = 1'b0;
          d.bitCnt = q.bitCnt - 3'h1;
          if (q.bitCnt == 3'h0)
            d.ms = MS_RXACK; // [R15]
        end
      MS_RXACK:
        if (!q.ph)
        begin
          d.sdaOe = 1'b0;
          if (tick)
          begin
            d.sclOe = 1'b0;
            d.ph    = 1'b1;
          end
        end
        else if (tick)
        begin
          d.rxAck = q.sdaS2;
          d.sclOe = 1'b1;
          d.ph    = 1'b0;
          if (q.addrPhase && q.addr[0] && !q.lost && !q.sdaS2) // [R10]
          begin
            d.ms     = MS_RXBIT; // [R7]
            d.bitCnt = 3'h7;
          end
          else
          begin
            d.master_write_flag      = 1'b1; // [R5] [R13]
            d.lastRead = 1'b0;
            if (q.lost)
            begin
              d.sclOe = 1'b0;
              d.ms    = MS_IDLE;
            end
            else
            begin
              d.clock_hold_flag = 1'b1; // [R5]
              d.ms      = MS_HOLD;
            end
          end
        end
      MS_RXBIT:
        if (!q.ph)
        begin
          d.sdaOe = 1'b0;
          if (tick)
          begin
            d.sclOe = 1'b0;
            d.ph    = 1'b1;
          end
        end
        else if (tick)
        begin
          d.shift  = {q.shift[6:0], q.sdaS2};
          d.sclOe  = 1'b1;
          d.ph     = 1'b0;
          d.bitCnt = q.bitCnt - 3'h1;
          if (q.bitCnt == 3'h0)
          begin
            d.ms       = MS_HOLD;
            d.clock_hold_flag  = 1'b1;
            d.lastRead = 1'b1;
            d.master_read_flag      = !d.bus_error_flag; // [R18]
            d.master_write_flag      = d.bus_error_flag; // [R18]
          end
        end
      MS_ACKTX:
        if (!q.ph)
        begin
          d.sdaOe = q.acknowledge_action == ACK_SEND; // [R23]
          if (tick)
          begin
            d.sclOe = 1'b0;
            d.ph    = 1'b1;
          end
        end
        else if (tick)
        begin
          d.sclOe = 1'b1;
          d.ph    = 1'b0;
          if (q.acknowledge_action == NACK_SEND && !q.sdaS2)
          begin
            d.arbitration_lost_flag = 1'b1;
            d.master_write_flag     = 1'b1; // [R18]
            d.sclOe   = 1'b0;
            d.ms      = MS_IDLE;
          end
          else if (q.restart)
          begin
            d.restart = 1'b0;
            d.ms      = MS_RSTART; // [R6]
          end
          else
          begin
            d.ms     = MS_RXBIT; // [R17]
            d.bitCnt = 3'h7;
          end
        end
      MS_RSTART:
        if (!q.ph)
        begin
          d.sdaOe = 1'b0;
          if (tick)
          begin
            d.sclOe = 1'b0;
            d.ph    = 1'b1;
          end
        end
        else if (tick)
        begin
          d.sdaOe = 1'b1;
          d.ph    = 1'b0;
          d.ms    = MS_START;
        end
      default:
        d.ms = MS_IDLE;
    endcase
    // software triggers, only where the fsm sits still
    if (doRead && arIdx == IDX_MASTER_SHIFT_DATA && q.ms == MS_HOLD && q.lastRead)
    begin
      d.master_read_flag     = 1'b0; // [R19]
      d.master_write_flag     = 1'b0;
      d.clock_hold_flag = 1'b0;
      d.restart = 1'b0;
      d.ph      = 1'b0;
      d.ms      = MS_ACKTX; // [R17]
    end
    if (dataWr && q.ms == MS_HOLD) // [R11]
    begin
      d.shift     = q.wByte;
      d.master_read_flag       = 1'b0; // [R16]
      d.master_write_flag       = 1'b0;
      d.clock_hold_flag   = 1'b0;
      d.addrPhase = 1'b0;
      d.ph        = 1'b0;
      d.bitCnt    = 3'h7;
      d.ms        = MS_TXBIT; // [R13]
    end
    if (addrWr) // [R2]
    begin
      d.addr      = q.wByte;
      d.master_read_flag       = 1'b0; // [R8]
      d.master_write_flag       = 1'b0;
      d.arbitration_lost_flag   = 1'b0;
      d.bus_error_flag    = 1'b0;
      d.clock_hold_flag   = 1'b0;
      d.lost      = 1'b0;
      d.addrPhase = 1'b1;
      d.ph        = 1'b0;
      if (q.bus == BUS_UNKNOWN)
      begin
        d.master_write_flag    = 1'b1; // [R3]
        d.bus_error_flag = 1'b1;
        d.ms     = MS_IDLE;
      end
      else if (q.bus == BUS_OWNER && q.ms == MS_HOLD)
      begin
        d.restart = q.lastRead;
        d.ms      = q.lastRead ? MS_ACKTX : MS_RSTART; // [R6]
      end
      else
        d.ms = MS_WAIT; // [R4]
    end
    // disabled master: bus released, state unknown
    if (!d.enable)
    begin
      d.ms      = MS_IDLE;
      d.sclOe   = 1'b0;
      d.sdaOe   = 1'b0;
      d.clock_hold_flag = 1'b0;
      d.bus     = BUS_UNKNOWN;
    end
    // slave address watch; the 4x clock margin lets the sampler see stops
    if (q.sctrl[SC_ENABLE])
    begin
      if (startSeen)
      begin
        d.sInFrame = 1'b1;
        d.sFirst   = 1'b1;
        d.sMatched = 1'b0;
        d.sBits    = 4'h0;
      end
      else if (stopSeen)
      begin
        d.sInFrame = 1'b0;
        if (q.sctrl[SC_SLAVE_STOP_IRQ_ENABLE])
        begin
          d.sApF = 1'b1; // [R21]
          d.sAp  = 1'b0;
        end
      end
      else if (sclRise && q.sInFrame)
      begin
        d.sBits  = (q.sBits == 4'h8) ? 4'h0 : q.sBits + 4'h1;
        d.sShift = rxByte[6:0];
        if (q.sBits == 4'h7 && q.sFirst)
        begin
          d.sFirst = 1'b0;
          if (q.sctrl[SC_PROMISCUOUS_MATCH_ENABLE] || rxByte[7:1] == q.sown[7:1]) // [R22]
          begin
            d.sMatched = 1'b1;
            d.sApF     = 1'b1;
            d.sAp      = 1'b1;
          end
        end
        else if (q.sBits == 4'h7 && q.sMatched)
          d.sDataF = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q       <= '0;
      q.awRdy <= 1'b1;
      q.wRdy  <= 1'b1;
      q.arRdy <= 1'b1;
      q.sclS1 <= 1'b1;
      q.sclS2 <= 1'b1;
      q.sdaS1 <= 1'b1;
      q.sdaS2 <= 1'b1;
      q.sclP  <= 1'b1;
      q.sdaP  <= 1'b1;
    end
    else
      q <= d;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_unknown_abort;
    addrWr && q.bus == BUS_UNKNOWN |=> q.master_write_flag && q.bus_error_flag && q.ms == MS_IDLE;
  endproperty
  a_unknown_abort: assert property (p_unknown_abort) // [R3]
    else $error("unknown bus did not abort");

  property p_addr_clears;
    addrWr && q.bus != BUS_UNKNOWN |=> !q.master_read_flag && !q.master_write_flag && !q.arbitration_lost_flag && !q.bus_error_flag;
  endproperty
  a_addr_clears: assert property (p_addr_clears) // [R8]
    else $error("address write left a master flag set");

  // between ticks a shifting fsm keeps shift and state, so any change is the write
  property p_data_ignored;
    dataWr && q.ms inside {MS_TXBIT, MS_RXBIT} && !tick |=> $stable(q.shift) && $stable(q.ms);
  endproperty
  a_data_ignored: assert property (p_data_ignored) // [R11]
    else $error("data write during shifting was taken");

  property p_data_starts;
    dataWr && q.ms == MS_HOLD |=> q.ms == MS_TXBIT && !q.master_read_flag && !q.master_write_flag && q.bitCnt == 3'h7;
  endproperty
  a_data_starts: assert property (p_data_starts) // [R16]
    else $error("data write did not start a clean byte send");

  property p_flags_exclusive;
    !(q.master_read_flag && q.master_write_flag);
  endproperty
  a_flags_exclusive: assert property (p_flags_exclusive) // [R18]
    else $error("read and write flags set together");

  property p_hold_low;
    q.clock_hold_flag |-> q.sclOe && q.ms == MS_HOLD;
  endproperty
  a_hold_low: assert property (p_hold_low) // [R5]
    else $error("clock hold flag without scl held low");

  property p_ones_after_loss;
    q.ms == MS_TXBIT && q.lost |-> !q.sdaOe;
  endproperty
  a_ones_after_loss: assert property (p_ones_after_loss) // [R15]
    else $error("drove sda low after arbitration loss");

  property p_addr_read_quiet;
    doRead && arIdx == IDX_MASTER_TARGET_ADDRESS && idleOrHold && !doWrite |=> $stable(q.ms);
  endproperty
  a_addr_read_quiet: assert property (p_addr_read_quiet) // [R9]
    else $error("address read started bus activity");

  property p_data_irq;
    ##1 q.dataIrq == $past(q.sctrl[SC_SLAVE_DATA_IRQ_ENABLE] && q.sDataF && globalIrqEnable);
  endproperty
  a_data_irq: assert property (p_data_irq) // [R20]
    else $error("slave data interrupt gating wrong");
endmodule

// File: core/two_wire_master_pkg.sv
// constants and types of the two-wire master byte engine
package two_wire_master_pkg;
  localparam int unsigned ADDR_W = 6;
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_MCTRL   = 4'h3;
  localparam logic [3:0] IDX_MASTER_STATUS_REG = 4'h5;
  localparam logic [3:0] IDX_MASTER_BAUD_RATE   = 4'h6;
  localparam logic [3:0] IDX_MASTER_TARGET_ADDRESS   = 4'h7;
  localparam logic [3:0] IDX_MASTER_SHIFT_DATA   = 4'h8;
  localparam logic [3:0] IDX_SLAVE_CONTROL_FIRST  = 4'h9;
  localparam logic [3:0] IDX_SLAVE_STATUS_REG = 4'hb;
  localparam logic [3:0] IDX_SLAVE_OWN_ADDRESS   = 4'hc;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  // master control fields
  localparam int unsigned MC_ENABLE = 0;
  localparam int unsigned MC_ACKNOWLEDGE_ACTION = 2;
  // master status fields
  localparam int unsigned ST_RIF     = 7;
  localparam int unsigned ST_WIF     = 6;
  localparam int unsigned ST_CLOCK_HOLD_FLAG = 5;
  localparam int unsigned ST_RXACK   = 4;
  localparam int unsigned ST_ARBITRATION_LOST_FLAG = 3;
  localparam int unsigned ST_BUS_ERROR_FLAG  = 2;
  localparam int unsigned ST_BUS     = 0;
  // slave control fields
  localparam int unsigned SC_SLAVE_DATA_IRQ_ENABLE   = 7;
  localparam int unsigned SC_SLAVE_ADDR_STOP_IRQ_ENABLE  = 6;
  localparam int unsigned SC_SLAVE_STOP_IRQ_ENABLE   = 5;
  localparam int unsigned SC_PROMISCUOUS_MATCH_ENABLE   = 2;
  localparam int unsigned SC_ENABLE = 0;
  // slave status fields
  localparam int unsigned SS_DIF  = 7;
  localparam int unsigned SS_SLAVE_ADDR_STOP_FLAG = 6;
  localparam int unsigned SS_AP   = 0;
  localparam logic ACK_SEND  = 1'b0;
  localparam logic NACK_SEND = 1'b1;
  // extra cycles added to the baud field for each half period
  localparam logic [8:0] HALF_EXTRA = 9'h005;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic [1:0]
  {
    BUS_UNKNOWN = 2'h0,
    BUS_IDLE    = 2'h1,
    BUS_OWNER   = 2'h2,
    BUS_BUSY    = 2'h3
  } bus_state_t;
endpackage

// File: sim/two_wire_master_byte_engine_bench.sv
// self-checking bench for the two-wire master byte engine
`timescale 1ns/1ps
module two_wire_master_byte_engine_bench;
  import two_wire_master_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0]       wdata = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              arvalid = 1'b0;
  logic              globalIrqEnable = 1'b1;
  logic              sdaPull = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              sclOe, sdaOe, slaveLow, slaveAddrStopIrq, slaveDataIrq;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata, rd, br;
  logic [7:0]        lastRx;
  int                mismatches = 0;
  int                comparisons = 0;
  int                cycles = 0;
  wire logic         sclIn = ~sclOe;
  // bench pull makes its own start and stop while the master is off
  wire logic         sdaIn = ~(sdaOe | slaveLow | sdaPull);
  localparam logic [3:0] RV [4] = '{IDX_MASTER_BAUD_RATE, IDX_MASTER_TARGET_ADDRESS, IDX_MASTER_SHIFT_DATA, IDX_SLAVE_CONTROL_FIRST};

  two_wire_master_byte_engine DUT (.sys_clk, .rst, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1),
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1),
    .sclIn, .sclOut(), .sclOe, .sdaIn, .sdaOut(), .sdaOe, .globalIrqEnable,
    .slaveDataIrq, .slaveAddrStopIrq);
  two_wire_slave_model slave (.scl(sclIn), .sda(sdaIn), .pullLow(slaveLow), .lastRx);

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        mismatches++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // ready lines stay high, so each answer is taken at the edge it is seen
  task automatic axw(input logic [3:0] idx, input logic [7:0] d);
    begin
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
        @(posedge sys_clk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
      end
      while (awvalid || wvalid);
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      br = {30'h0, bresp};
    end
  endtask

  task automatic axr(input logic [3:0] idx);
    begin
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rd = (rresp === RESP_OKAY) ? rdata : {30'h0, rresp};
    end
  endtask

  task automatic waitSt(input int b);
    begin
      do axr(IDX_MASTER_STATUS_REG); while (rd[b] !== 1'b1);
    end
  endtask

  task automatic summarize();
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // a hung wait counts against the run
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (RV[i])
    begin
      axr(RV[i]);
      chk(rd, 32'h0);
    end
    axr(4'hf);
    chk(rd, {30'h0, RESP_DECERR});
    axw(4'hf, 8'h00);
    chk(br, {30'h0, RESP_DECERR});
    axw(IDX_MASTER_BAUD_RATE, 8'h03);
    chk(br, {30'h0, RESP_OKAY});
    axr(IDX_MASTER_BAUD_RATE);
    chk(rd, 32'h03);
    $display("test registers done");
    axw(IDX_MCTRL, 8'h01);
    axw(IDX_SLAVE_CONTROL_FIRST, 8'hc5);
    axw(IDX_MASTER_TARGET_ADDRESS, 8'ha0);
    axr(IDX_MASTER_STATUS_REG);
    chk(rd, 32'h44);
    axw(IDX_MASTER_STATUS_REG, 8'h01);
    axr(IDX_MASTER_STATUS_REG);
    chk(rd, 32'h45);
    axw(IDX_MASTER_TARGET_ADDRESS, 8'ha0);
    waitSt(ST_WIF);
    chk(rd, 32'h62);
    axr(IDX_MASTER_TARGET_ADDRESS);
    chk(rd, 32'ha0);
    axr(IDX_SLAVE_STATUS_REG);
    chk(rd & 32'h41, 32'h41);
    chk({31'h0, slaveAddrStopIrq}, 32'h1);
    $display("test address write done");
    // second write lands mid-shift and must be dropped
    axw(IDX_MASTER_SHIFT_DATA, 8'h5a);
    axw(IDX_MASTER_SHIFT_DATA, 8'h11);
    waitSt(ST_WIF);
    chk(rd, 32'h62);
    chk({24'h0, lastRx}, 32'h5a);
    $display("test data write done");
    axw(IDX_MASTER_TARGET_ADDRESS, 8'ha1);
    waitSt(ST_RIF);
    chk(rd, 32'ha2);
    axr(IDX_MASTER_SHIFT_DATA);
    chk(rd, 32'h3c);
    waitSt(ST_RIF);
    chk(rd, 32'ha2);
    axw(IDX_MCTRL, 8'h05);
    axr(IDX_MASTER_SHIFT_DATA);
    chk(rd, 32'h3c);
    waitSt(ST_RIF);
    chk(rd, 32'ha2);
    $display("test data read done");
    chk({31'h0, slaveDataIrq}, 32'h1);
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({30'h0, slaveDataIrq, slaveAddrStopIrq}, 32'h0);
    globalIrqEnable <= 1'b1;
    axw(IDX_MCTRL, 8'h00);
    axr(IDX_MASTER_STATUS_REG);
    chk(rd & 32'h3, 32'h0);
    $display("test disable done");
    // clear slave flags, arm the stop flag, then start and stop on an idle bus
    axw(IDX_SLAVE_STATUS_REG, 8'hc0);
    axw(IDX_SLAVE_CONTROL_FIRST, 8'he5);
    sdaPull <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sdaPull <= 1'b0;
    repeat (8) @(posedge sys_clk);
    axr(IDX_SLAVE_STATUS_REG);
    chk(rd, 32'h40);
    chk({31'h0, slaveAddrStopIrq}, 32'h1);
    $display("test stop flag done");
    summarize();
  end
endmodule

// File: sim/two_wire_slave_model.sv
// behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module two_wire_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h50,
  parameter logic [7:0] TX_BYTE  = 8'h3c
) (
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       pullLow,
  output logic [7:0] lastRx
);
  int         cnt;
  logic [7:0] sh;
  logic       addrPh;
  logic       sel;
  logic       rd;
  initial
  begin
    pullLow = 1'b0;
    lastRx = 8'h00;
    cnt = 0;
    sh = 8'h00;
    addrPh = 1'b0;
    sel = 1'b0;
    rd = 1'b0;
  end
  // start or repeated start re-arms the address phase
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      addrPh = 1'b1;
      pullLow = 1'b0;
    end
  always @(posedge scl)
  begin
    cnt = cnt + 1;
    if (cnt <= 8)
      sh = {sh[6:0], sda};
  end
  // changes only while clock low; released line reads high by the pull-up
  always @(negedge scl)
    if (cnt == 8)
    begin
      if (addrPh)
      begin
        sel = (sh[7:1] == OWN_ADDR);
        rd = sh[0];
      end
      else if (!rd)
        lastRx = sh;
      pullLow = sel && !(rd && !addrPh);
    end
    else if (cnt == 9)
    begin
      cnt = 0;
      addrPh = 1'b0;
      pullLow = sel && rd && !TX_BYTE[7];
    end
    else if (cnt > 0)
      pullLow = sel && rd && !addrPh && !TX_BYTE[7 - cnt];
endmodule
